// ===== sys_ctrl_block.sv
// System control register bank with wake and sleep-on-exit control
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sys_ctrl_regs.svh"
module sys_ctrl_block
	import sys_ctrl_pkg::*;
#(
	parameter logic BIG_ENDIAN = 1'b0
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [`ADDR_W-1:0]    adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	input  wire logic [`IRQ_LINES-1:0] irq_pend_i,
	input  wire logic [`IRQ_LINES-1:0] irq_en_i,
	input  wire logic [5:0]            program_status_exception_field_i,
	input  wire logic                  handler_return_i,
	input  wire logic                  wait_for_event_instruction_i,
	input  wire logic                  wait_for_interrupt_i,
	input  wire logic                  send_event_instruction_i,
	output logic                       deferred_service_exception_o,
	output logic                       tick_exception_o,
	output logic                       system_reset_request_o,
	output logic                       core_sleeping_o,
	output logic                       deep_sleep_select_o
);

	// ------------------------------------------------------------------
	// Internal state
	// ------------------------------------------------------------------
	pend_arb_if arb_if ();
	logic        defer_pend_q;
	logic        tick_pend_q;
	logic        wake_any_q;
	logic        deep_sel_q;
	logic        sleep_exit_q;
	logic        event_latch_q;
	logic [31:0] prev_pend_q;
	logic [5:0]  active_q;
	logic [5:0]  top_q;
	logic        any_q;
	pwr_state_t  pwr_q;
	logic        wr_stb;
	logic        rd_stb;
	logic        key_ok;
	logic        new_pend;
	logic        wake_evt;
	logic        wake_int;
	logic [31:0] rd_d;

	// ------------------------------------------------------------------
	// Arbiter
	// ------------------------------------------------------------------
	assign arb_if.irq_pend   = irq_pend_i;
	assign arb_if.irq_en     = irq_en_i;
	assign arb_if.defer_pend = defer_pend_q;
	assign arb_if.tick_pend  = tick_pend_q;

	pend_arbiter u_arb (
		.p (arb_if.arb)
	);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// Single-cycle ack; the strobe is masked during ack so each access acts once
	assign wr_stb = cyc_i & stb_i & we_i & ~ack_o;
	assign rd_stb = cyc_i & stb_i & ~we_i & ~ack_o;
	assign key_ok = (dat_i[31:`ARC_KEY_LSB] == `ARC_KEY_VALUE) & (&sel_i[3:2]);

	// Ack pulse for one cycle per request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i & stb_i & ~ack_o;
	end

	// ------------------------------------------------------------------
	// Pending state of the two system exceptions
	// ------------------------------------------------------------------
	// Set wins over clear should software break the one-bit-per-write habit
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			defer_pend_q <= 1'b0;
			tick_pend_q  <= 1'b0;
		end else if (wr_stb && adr_i == `OFS_INTERRUPT_CONTROL_STATE && sel_i[3]) begin
			if (dat_i[`ICS_DEFER_SET_BIT])
				defer_pend_q <= 1'b1;
			else if (dat_i[`ICS_DEFER_CLR_BIT])
				defer_pend_q <= 1'b0;
			if (dat_i[`ICS_TICK_SET_BIT])
				tick_pend_q <= 1'b1;
			else if (dat_i[`ICS_TICK_CLR_BIT])
				tick_pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Low power control register
	// ------------------------------------------------------------------
	// Only bits 4, 2 and 1 are stored; the rest ignore writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_any_q   <= 1'b0;
			deep_sel_q   <= 1'b0;
			sleep_exit_q <= 1'b0;
		end else if (wr_stb && adr_i == `OFS_LOW_POWER_CONTROL && sel_i[0]) begin
			wake_any_q   <= dat_i[`LPC_WAKE_ANY_BIT];
			deep_sel_q   <= dat_i[`LPC_DEEP_SLEEP_BIT];
			sleep_exit_q <= dat_i[`LPC_SLEEP_EXIT_BIT];
		end
	end

	// ------------------------------------------------------------------
	// System reset request
	// ------------------------------------------------------------------
	// Held until the system reset takes this block down
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			system_reset_request_o <= 1'b0;
		else if (wr_stb && adr_i == `OFS_APPLICATION_RESET_CONTROL && key_ok &&
			sel_i[0] && dat_i[`ARC_SYS_RESET_BIT])
			system_reset_request_o <= 1'b1;
	end

	// ------------------------------------------------------------------
	// Status snapshots
	// ------------------------------------------------------------------
	// Registered so the read path sees one consistent cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active_q <= 6'h00;
			top_q    <= 6'h00;
			any_q    <= 1'b0;
		end else begin
			active_q <= program_status_exception_field_i;
			top_q    <= arb_if.top_num;
			any_q    <= arb_if.any_irq;
		end
	end

	// ------------------------------------------------------------------
	// Wake events
	// ------------------------------------------------------------------
	// Rising pending edges; disabled lines count only with wake-any set
	assign new_pend = |(irq_pend_i & ~prev_pend_q & (wake_any_q ? '1 : irq_en_i));
	assign wake_evt = new_pend | send_event_instruction_i;
	assign wake_int = |(irq_pend_i & irq_en_i) | defer_pend_q | tick_pend_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			prev_pend_q <= 32'h0000_0000;
		else
			prev_pend_q <= irq_pend_i;
	end

	// Event latch: set by an event while awake, consumed by the next wait
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			event_latch_q <= 1'b0;
		else if (pwr_q == PWR_RUN && wake_evt)
			event_latch_q <= 1'b1;
		else if (pwr_q == PWR_RUN && wait_for_event_instruction_i)
			event_latch_q <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pwr_q <= PWR_RUN;
		else begin
			unique case (pwr_q)
				PWR_RUN: begin
					if (wait_for_event_instruction_i && !event_latch_q && !wake_evt)
						pwr_q <= PWR_WAIT;
					else if (wait_for_interrupt_i)
						pwr_q <= PWR_SLEEP;
					else if (handler_return_i && sleep_exit_q)
						pwr_q <= PWR_SLEEP;
				end
				PWR_SLEEP: begin
					if (new_pend || wake_int)
						pwr_q <= PWR_RUN;
				end
				PWR_WAIT: begin
					if (wake_evt)
						pwr_q <= PWR_RUN;
				end
				default: pwr_q <= PWR_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			deferred_service_exception_o <= 1'b0;
			tick_exception_o             <= 1'b0;
			core_sleeping_o              <= 1'b0;
			deep_sleep_select_o          <= 1'b0;
		end else begin
			deferred_service_exception_o <= defer_pend_q;
			tick_exception_o             <= tick_pend_q;
			core_sleeping_o              <= (pwr_q != PWR_RUN);
			deep_sleep_select_o          <= deep_sel_q;
		end
	end

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	// Key field reads zero (unknown is allowed); bits 2 and 1 read zero
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (adr_i)
			`OFS_INTERRUPT_CONTROL_STATE: begin
				rd_d[`ICS_DEFER_SET_BIT] = defer_pend_q;
				rd_d[`ICS_TICK_SET_BIT]  = tick_pend_q;
				rd_d[`ICS_ANY_PEND_BIT]  = any_q;
				rd_d[`ICS_TOP_PEND_LSB +: `EXC_NUM_W] = top_q;
				rd_d[`EXC_NUM_W-1:0] = active_q;
			end
			`OFS_APPLICATION_RESET_CONTROL:
				rd_d[`ARC_BYTE_ORDER_BIT] = BIG_ENDIAN;
			`OFS_LOW_POWER_CONTROL: begin
				rd_d[`LPC_WAKE_ANY_BIT]   = wake_any_q;
				rd_d[`LPC_DEEP_SLEEP_BIT] = deep_sel_q;
				rd_d[`LPC_SLEEP_EXIT_BIT] = sleep_exit_q;
			end
			`OFS_CORE_STATUS:
				rd_d[2:0] = pwr_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// Read data latched with the ack
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			dat_o <= 32'h0000_0000;
		else if (rd_stb)
			dat_o <= rd_d;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	bad_key_ignored_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_stb && adr_i == `OFS_APPLICATION_RESET_CONTROL && !key_ok && !system_reset_request_o)
		|=> !system_reset_request_o)
		else $error("unkeyed write changed reset request");

	reset_req_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_stb && adr_i == `OFS_APPLICATION_RESET_CONTROL && key_ok && sel_i[0] &&
		dat_i[`ARC_SYS_RESET_BIT]) |=> system_reset_request_o)
		else $error("keyed reset request not raised");

	reset_reads_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_stb && adr_i == `OFS_APPLICATION_RESET_CONTROL) |=> (dat_o[2:1] == 2'b00))
		else $error("reset control low bits not zero");

	byte_order_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_stb && adr_i == `OFS_APPLICATION_RESET_CONTROL) |=>
		(dat_o[`ARC_BYTE_ORDER_BIT] == BIG_ENDIAN))
		else $error("byte order bit wrong");

	active_follows_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		##1 active_q == $past(program_status_exception_field_i))
		else $error("active field differs from status");

	any_pend_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(irq_pend_i != 32'h0000_0000) ##1 (irq_pend_i != 32'h0000_0000) |-> any_q)
		else $error("pending flag missing");

	top_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		((irq_pend_i & irq_en_i) == 32'h0 && !defer_pend_q && !tick_pend_q) |=> top_q == 6'h00)
		else $error("top pending not zero when idle");

	wait_wake_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pwr_q == PWR_WAIT && send_event_instruction_i) |=> pwr_q == PWR_RUN)
		else $error("send event did not wake");

	exit_sleep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pwr_q == PWR_RUN && handler_return_i && sleep_exit_q && !wait_for_event_instruction_i)
		|=> pwr_q == PWR_SLEEP ##1 core_sleeping_o)
		else $error("sleep on exit missed");

	reserved_lpc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_stb && adr_i == `OFS_LOW_POWER_CONTROL) |=> (dat_o & ~`LPC_WRITE_MASK) == 32'h0)
		else $error("reserved low power bits set");

	no_pend_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(irq_pend_i == 32'h0000_0000) |=> !any_q)
		else $error("pending flag set with nothing pending");

	top_tick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(tick_pend_q && !defer_pend_q) |=> top_q == `EXC_TICK_NUM)
		else $error("tick exception not reported as top pending");

	// A latched event must turn the next wait into a no-op, not a stall
	latch_consumed_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pwr_q == PWR_RUN && wait_for_event_instruction_i && event_latch_q && !wake_evt)
		|=> (!event_latch_q && pwr_q != PWR_WAIT))
		else $error("latched event not consumed by wait");

	wake_enabled_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pwr_q == PWR_WAIT && (irq_pend_i & ~prev_pend_q & irq_en_i) != 32'h0000_0000)
		|=> pwr_q == PWR_RUN)
		else $error("enabled pending line did not wake");

	// Sticky so a slow system reset still sees the request
	reset_req_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		system_reset_request_o |=> system_reset_request_o)
		else $error("reset request dropped before reset");

endmodule
`default_nettype wire

// ===== sys_ctrl_regs.svh
// Register offsets, field positions, reset values and keys of the system control block
`ifndef SYS_CTRL_REGS_SVH
`define SYS_CTRL_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_INTERRUPT_CONTROL_STATE   6'h04
`define OFS_APPLICATION_RESET_CONTROL 6'h0C
`define OFS_LOW_POWER_CONTROL         6'h10
`define OFS_CORE_STATUS               6'h20
`define ADDR_W                        6

// ----------------------------------------------------------------------
// Interrupt control state fields
// ----------------------------------------------------------------------
`define ICS_DEFER_SET_BIT   28
`define ICS_DEFER_CLR_BIT   27
`define ICS_TICK_SET_BIT    26
`define ICS_TICK_CLR_BIT    25
`define ICS_ANY_PEND_BIT    22
`define ICS_TOP_PEND_LSB    12
`define EXC_NUM_W           6
`define EXC_IRQ_BASE        6'h10
`define EXC_DEFER_NUM       6'h0E
`define EXC_TICK_NUM        6'h0F
`define IRQ_LINES           32

// ----------------------------------------------------------------------
// Application reset control fields
// ----------------------------------------------------------------------
`define ARC_KEY_LSB         16
`define ARC_KEY_VALUE       16'h05FA
`define ARC_BYTE_ORDER_BIT  15
`define ARC_SYS_RESET_BIT   2
`define ARC_DEBUG_CLR_BIT   1

// ----------------------------------------------------------------------
// Low power control fields and reset value
// ----------------------------------------------------------------------
`define LPC_WAKE_ANY_BIT    4
`define LPC_DEEP_SLEEP_BIT  2
`define LPC_SLEEP_EXIT_BIT  1
`define LPC_WRITE_MASK      32'h0000_0016
`define LPC_RESET           32'h0000_0000

`endif

// ===== sys_ctrl_pkg.sv
// Types shared by the system control block files
`default_nettype none
package sys_ctrl_pkg;
	typedef enum logic [2:0] {
		PWR_RUN   = 3'b001,
		PWR_SLEEP = 3'b010,
		PWR_WAIT  = 3'b100
	} pwr_state_t;
endpackage
`default_nettype wire

// ===== pend_arb_if.sv
// Interface between the pending-exception arbiter and the register bank
`timescale 1ns/1ns
`default_nettype none
`include "sys_ctrl_regs.svh"
interface pend_arb_if;
	logic [`IRQ_LINES-1:0] irq_pend;
	logic [`IRQ_LINES-1:0] irq_en;
	logic                  defer_pend;
	logic                  tick_pend;
	logic [5:0]            top_num;
	logic                  any_irq;
	modport arb (input irq_pend, input irq_en, input defer_pend, input tick_pend,
		output top_num, output any_irq);
	modport bank (output irq_pend, output irq_en, output defer_pend, output tick_pend,
		input top_num, input any_irq);
endinterface
`default_nettype wire

// ===== pend_arbiter.sv
// Picks the highest-priority pending enabled exception number
`timescale 1ns/1ns
`default_nettype none
`include "sys_ctrl_regs.svh"
module pend_arbiter
	import sys_ctrl_pkg::*;
(
	pend_arb_if.arb p
);
	logic [`IRQ_LINES-1:0] live;
	logic [`IRQ_LINES:0]   found;
	logic [5:0]            pick [`IRQ_LINES:0];

	// Enabled and pending lines
	assign live = p.irq_pend & p.irq_en;
	assign found[`IRQ_LINES] = 1'b0;
	assign pick[`IRQ_LINES] = 6'h00;

	// Lowest line wins; line index plus base gives the exception number
	// Counting up keeps the genvar non-negative; the chain order lies in the indices
	genvar g;
	generate
		for (g = 0; g < `IRQ_LINES; g = g + 1) begin : g_pri
			assign found[g] = live[g] | found[g+1];
			assign pick[g]  = live[g] ? 6'(`EXC_IRQ_BASE + g) : pick[g+1];
		end
	endgenerate

	// System exceptions outrank external lines here at equal priority
	always_comb begin
		if (p.tick_pend)
			p.top_num = (p.defer_pend) ? `EXC_DEFER_NUM : `EXC_TICK_NUM;
		else if (p.defer_pend)
			p.top_num = `EXC_DEFER_NUM;
		else
			p.top_num = found[0] ? pick[0] : 6'h00;
	end

	// Any pending line counts, enabled or not
	assign p.any_irq = |p.irq_pend;
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the system control register bank
`timescale 1ns/1ns
`default_nettype none
`include "sys_ctrl_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
	// ------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------
	logic        clk_i, rst_n_i, cyc, stb, we, ack, hret, wait_for_event_instruction, wfi, send_event_instruction;
	logic        defer, tick, sysreq, sleeping, deep;
	logic [5:0]  adr, psr;
	logic [3:0]  sel;
	logic [31:0] dat_w, dat_r, irq_pend, irq_en, r;
	int          err_total, checks, cycles;

	sys_ctrl_block #(.BIG_ENDIAN(1'b1)) i_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
		.irq_pend_i(irq_pend), .irq_en_i(irq_en), .program_status_exception_field_i(psr),
		.handler_return_i(hret), .wait_for_event_instruction_i(wait_for_event_instruction),
		.wait_for_interrupt_i(wfi), .send_event_instruction_i(send_event_instruction),
		.deferred_service_exception_o(defer), .tick_exception_o(tick),
		.system_reset_request_o(sysreq), .core_sleeping_o(sleeping),
		.deep_sleep_select_o(deep));

	// ------------------------------------------------------------------
	// Clock, hang guard and verdict
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Whole run needs well under 2000 cycles; the margin covers slow acks
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			conclude();
		end
	end
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Shared drivers
	// ------------------------------------------------------------------
	// Classic cycle: hold everything until ack is sampled, then release
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dat_r;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (n >= 50) `CHK(ack, 1'b1)
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic lines(input logic [31:0] p, input logic [31:0] e);
		@(posedge clk_i);
		irq_pend <= p; irq_en <= e;
	endtask
	// One-cycle pulse: 0 wait for event, 1 send event, 2 handler return
	task automatic pulse(input int k);
		@(posedge clk_i);
		case (k)
			0: wait_for_event_instruction <= 1'b1;
			1: send_event_instruction <= 1'b1;
			default: hret <= 1'b1;
		endcase
		@(posedge clk_i);
		wait_for_event_instruction <= 1'b0; send_event_instruction <= 1'b0; hret <= 1'b0;
	endtask
	// Bounded wait for the sleep flag, then judge it
	task automatic expect_sleep(input logic e);
		int n;
		n = 0;
		while (sleeping !== e && n < 8) begin
			@(posedge clk_i);
			n++;
		end
		`CHK(sleeping, e)
	endtask
	task automatic do_reset();
		rst_n_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_and_holes();
		bus(1'b0, `OFS_LOW_POWER_CONTROL, 0, r); `CHK(r, 32'h0000_0000)
		bus(1'b0, `OFS_APPLICATION_RESET_CONTROL, 0, r); `CHK(r, 32'h0000_8000)
		wr(6'h08, 32'hFFFF_FFFF);
		bus(1'b0, 6'h08, 0, r); `CHK(r, 32'h0000_0000)
	endtask
	// Status table: pending lines, enables, active number, expected word
	task automatic t_status();
		logic [31:0] p[5] = '{32'h20, 32'h88, 32'h8000_0000, 32'h200, 32'h0};
		logic [31:0] e[5] = '{32'h20, 32'h88, 32'h8000_0000, 32'h0, 32'h0};
		logic [5:0]  a[5] = '{6'h25, 6'h00, 6'h3F, 6'h10, 6'h00};
		logic [31:0] x[5] = '{32'h0041_5025, 32'h0041_3000, 32'h0042_F03F,
			32'h0040_0010, 32'h0000_0000};
		for (int i = 0; i < 5; i++) begin
			lines(p[i], e[i]);
			psr <= a[i];
			repeat (2) @(posedge clk_i);
			bus(1'b0, `OFS_INTERRUPT_CONTROL_STATE, 0, r); `CHK(r, x[i])
		end
	endtask
	// Software pending bits; bit 22 is masked as its view of these is open
	task automatic t_soft_pending();
		logic [31:0] w[4] = '{32'h1000_0000, 32'h0400_0000, 32'h0800_0000, 32'h0200_0000};
		logic [31:0] x[4] = '{32'h1000_E000, 32'h1400_E000, 32'h0400_F000, 32'h0};
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_INTERRUPT_CONTROL_STATE, w[i]);
			bus(1'b0, `OFS_INTERRUPT_CONTROL_STATE, 0, r);
			`CHK(r & 32'hFFBF_FFFF, x[i])
			`CHK({defer, tick}, {x[i][28], x[i][26]})
		end
	endtask
	task automatic t_low_power_reg();
		// Every bit but deep sleep, which software must keep clear
		wr(`OFS_LOW_POWER_CONTROL, 32'hFFFF_FFFB);
		bus(1'b0, `OFS_LOW_POWER_CONTROL, 0, r); `CHK(r, 32'h0000_0012)
		`CHK(deep, 1'b0)
		wr(`OFS_LOW_POWER_CONTROL, 32'h0);
		bus(1'b0, `OFS_LOW_POWER_CONTROL, 0, r); `CHK(r, 32'h0)
		`CHK(deep, 1'b0)
	endtask
	task automatic t_wake();
		// Lines rose earlier while running, so one event is still latched
		pulse(0);
		repeat (4) @(posedge clk_i);
		`CHK(sleeping, 1'b0)
		pulse(0); expect_sleep(1'b1);
		bus(1'b0, `OFS_CORE_STATUS, 0, r); `CHK(r, 32'h0000_0004)
		lines(32'h10, 32'h0);
		repeat (4) @(posedge clk_i);
		`CHK(sleeping, 1'b1)
		pulse(1); expect_sleep(1'b0);
		lines(32'h0, 32'h10);
		lines(32'h10, 32'h10);
		lines(32'h0, 32'h10);
		pulse(0);
		repeat (4) @(posedge clk_i);
		`CHK(sleeping, 1'b0)
		pulse(0); expect_sleep(1'b1);
		lines(32'h10, 32'h10); expect_sleep(1'b0);
		lines(32'h0, 32'h0);
		wr(`OFS_LOW_POWER_CONTROL, 32'h10);
		pulse(0); expect_sleep(1'b1);
		lines(32'h40, 32'h0); expect_sleep(1'b0);
		lines(32'h0, 32'h0);
	endtask
	task automatic t_sleep_on_exit();
		wr(`OFS_LOW_POWER_CONTROL, 32'h02);
		pulse(2); expect_sleep(1'b1);
		bus(1'b0, `OFS_CORE_STATUS, 0, r); `CHK(r, 32'h0000_0002)
		lines(32'h4, 32'h4); expect_sleep(1'b0);
		lines(32'h0, 32'h0);
		wr(`OFS_LOW_POWER_CONTROL, 32'h0);
		pulse(2);
		repeat (4) @(posedge clk_i);
		`CHK(sleeping, 1'b0)
	endtask
	task automatic t_keyed_reset();
		wr(`OFS_APPLICATION_RESET_CONTROL, 32'h05FB_0004);
		wr(`OFS_APPLICATION_RESET_CONTROL, 32'h0000_05FA);
		`CHK(sysreq, 1'b0)
		wr(`OFS_APPLICATION_RESET_CONTROL, 32'h05FA_0000);
		`CHK(sysreq, 1'b0)
		wr(`OFS_APPLICATION_RESET_CONTROL, 32'h05FA_0004);
		bus(1'b0, `OFS_APPLICATION_RESET_CONTROL, 0, r); `CHK(r, 32'h0000_8000)
		`CHK(sysreq, 1'b1)
		do_reset();
		@(posedge clk_i);
		`CHK(sysreq, 1'b0)
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rst_n_i = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0;
		dat_w = '0; irq_pend = '0; irq_en = '0; psr = '0; hret = 1'b0;
		wait_for_event_instruction = 1'b0; wfi = 1'b0; send_event_instruction = 1'b0;
		err_total = 0; checks = 0; cycles = 0;
		do_reset();
		t_reset_and_holes();
		t_status();
		t_soft_pending();
		t_low_power_reg();
		t_wake();
		t_sleep_on_exit();
		t_keyed_reset();
		conclude();
	end
endmodule
`default_nettype wire
